// File: shared/motion_sleep_map.vh
// register offsets, fields, reset values and timing counts of the motion sleep sequencer
`ifndef MOTION_SLEEP_MAP_VH
`define MOTION_SLEEP_MAP_VH

// register word offsets (index, byte address is four times it)
`define MS_CTRL_OFS        8'h00
`define MS_STATUS_OFS      8'h01
`define MS_INT_STATUS_OFS  8'h02
`define MS_INT_MASK_OFS    8'h03
`define MS_LEVEL_BASE_OFS  8'h10
// per level: base + 4*level + field
`define MS_FLD_SLEEP_TIME  2'h0
`define MS_FLD_THRESHOLD   2'h1
`define MS_FLD_DWELL_TIME  2'h2

// control register fields
`define MS_CTRL_ENABLE_BIT 0

// interrupt status bits
`define MS_IRQ_WAKE_BIT    0
`define MS_IRQ_MOTION_BIT  1
`define MS_IRQ_STEP_BIT    2
`define MS_IRQ_WIDTH       3

// reset values
`define MS_CTRL_RESET      32'h0000_0000
`define MS_SLEEP_RESET     16'h0064
`define MS_THRESH_RESET    16'h0001
`define MS_DWELL_RESET     16'h0004

// timing
`define MS_CLK_HZ          10000000
`define MS_CHECK_TIME_US   2300
`define MS_TICK_TIME_US    1000

`endif

// File: rtl/motion_sleep_sequencer.v
// power-mode sequencer moving the sensor between tracking, inactive and four sleep levels
`timescale 1ns/1ps
`default_nettype none
`include "motion_sleep_map.vh"

module motion_sleep_sequencer #(
    parameter integer LEVELS     = 4,
    parameter integer PW         = 16,
    // cycles per millisecond tick of the sleep and dwell timers
    parameter integer TICK_CYC   = (`MS_CLK_HZ / 1000) * `MS_TICK_TIME_US / 1000,
    // cycles of one motion check, exactly 2.3 ms at the 10 MHz clock
    parameter integer CHECK_CYC  = (`MS_CLK_HZ / 1000) * `MS_CHECK_TIME_US / 1000,
    // millisecond ticks without motion in tracking before sleep progression starts
    parameter integer IDLE_TICKS = 100
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        reset,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // motion from the signal processor, amount per sample
    input  wire        motion_valid,
    input  wire [15:0] motion_amount,
    // power gates and mode indication
    output reg         laser_on,
    output reg         detector_on,
    output reg         tracking,
    output reg         irq
);

    localparam [4:0] ST_TRACK  = 5'b00001;
    localparam [4:0] ST_IDLE   = 5'b00010;
    localparam [4:0] ST_INACT  = 5'b00100;
    localparam [4:0] ST_CHECK  = 5'b01000;
    localparam [4:0] ST_SPARE  = 5'b10000;

    // level parameters, one array per field
    reg  [PW-1:0] sleep_time_reg [0:LEVELS-1];
    reg  [PW-1:0] threshold_reg  [0:LEVELS-1];
    reg  [PW-1:0] dwell_time_reg [0:LEVELS-1];

    reg           enable_reg;
    reg  [`MS_IRQ_WIDTH-1:0] int_status_reg;
    reg  [`MS_IRQ_WIDTH-1:0] int_mask_reg;
    reg  [4:0]    state_reg;
    reg  [1:0]    level_reg;
    reg  [31:0]   tick_cnt_reg;
    reg  [PW-1:0] sleep_cnt_reg;
    reg  [PW-1:0] dwell_cnt_reg;
    reg  [31:0]   check_cnt_reg;
    reg  [PW-1:0] idle_cnt_reg;

    wire          tick = (tick_cnt_reg == TICK_CYC - 1);
    // deepest level index, cut on purpose to the width of the level register
    wire [31:0]   last_level_w = LEVELS - 1;
    wire [1:0]    last_level = last_level_w[1:0];
    wire          lvl_hit = reg_addr >= `MS_LEVEL_BASE_OFS &&
                            reg_addr < `MS_LEVEL_BASE_OFS + 4 * LEVELS;
    wire [7:0]    lvl_off = reg_addr - `MS_LEVEL_BASE_OFS;
    wire [1:0]    lvl_sel = lvl_off[3:2];
    wire [1:0]    fld_sel = lvl_off[1:0];
    wire          motion_big = motion_valid &&
                               motion_amount >= threshold_reg[level_reg];

    // event pulses for the interrupt status
    reg           ev_wake;
    reg           ev_motion;
    reg           ev_step;

    // per-level parameter registers, written by software
    genvar g;
    generate
        for (g = 0; g < LEVELS; g = g + 1) begin : g_level
            always @(posedge clk_sys) begin
                if (reset) begin
                    sleep_time_reg[g] <= `MS_SLEEP_RESET;
                    threshold_reg[g]  <= `MS_THRESH_RESET;
                    dwell_time_reg[g] <= `MS_DWELL_RESET;
                end else if (reg_wr && lvl_hit && lvl_sel == g) begin
                    case (fld_sel)
                        `MS_FLD_SLEEP_TIME: sleep_time_reg[g] <= reg_wdata[PW-1:0];
                        `MS_FLD_THRESHOLD:  threshold_reg[g]  <= reg_wdata[PW-1:0];
                        `MS_FLD_DWELL_TIME: dwell_time_reg[g] <= reg_wdata[PW-1:0];
                        default: ;
                    endcase
                end
            end
        end
    endgenerate

    // control, mask and interrupt status; a new event wins over a clear
    always @(posedge clk_sys) begin
        if (reset) begin
            enable_reg     <= 1'b0;
            int_mask_reg   <= {`MS_IRQ_WIDTH{1'b0}};
            int_status_reg <= {`MS_IRQ_WIDTH{1'b0}};
        end else begin
            if (reg_wr && reg_addr == `MS_CTRL_OFS)
                enable_reg <= reg_wdata[`MS_CTRL_ENABLE_BIT];
            if (reg_wr && reg_addr == `MS_INT_MASK_OFS)
                int_mask_reg <= reg_wdata[`MS_IRQ_WIDTH-1:0];
            int_status_reg <= (int_status_reg &
                               ~((reg_wr && reg_addr == `MS_INT_STATUS_OFS) ?
                                 reg_wdata[`MS_IRQ_WIDTH-1:0] : {`MS_IRQ_WIDTH{1'b0}}))
                              | {ev_step, ev_motion, ev_wake};
        end
    end

    // read data, one cycle after the strobe; unmapped reads give zero
    always @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (lvl_hit) begin
                case (fld_sel)
                    `MS_FLD_SLEEP_TIME: reg_rdata <= {{(32-PW){1'b0}}, sleep_time_reg[lvl_sel]};
                    `MS_FLD_THRESHOLD:  reg_rdata <= {{(32-PW){1'b0}}, threshold_reg[lvl_sel]};
                    `MS_FLD_DWELL_TIME: reg_rdata <= {{(32-PW){1'b0}}, dwell_time_reg[lvl_sel]};
                    default:            reg_rdata <= 32'h0000_0000;
                endcase
            end else begin
                case (reg_addr)
                    `MS_CTRL_OFS:       reg_rdata <= {31'h0, enable_reg};
                    `MS_STATUS_OFS:     reg_rdata <= {25'h0, level_reg, state_reg};
                    `MS_INT_STATUS_OFS: reg_rdata <= {29'h0, int_status_reg};
                    `MS_INT_MASK_OFS:   reg_rdata <= {29'h0, int_mask_reg};
                    default:            reg_rdata <= 32'h0000_0000;
                endcase
            end
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // millisecond prescaler; keeps running in the inactive state as the wake timer base
    always @(posedge clk_sys) begin
        if (reset || tick)
            tick_cnt_reg <= 32'h0000_0000;
        else
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end

    // sleep sequencer; hardware walks the levels with no software help
    always @(posedge clk_sys) begin
        ev_wake   <= 1'b0;
        ev_motion <= 1'b0;
        ev_step   <= 1'b0;
        if (reset) begin
            state_reg     <= ST_TRACK;
            level_reg     <= 2'h0;
            sleep_cnt_reg <= {PW{1'b0}};
            dwell_cnt_reg <= {PW{1'b0}};
            check_cnt_reg <= 32'h0000_0000;
            idle_cnt_reg  <= {PW{1'b0}};
        end else if (!enable_reg) begin
            state_reg    <= ST_TRACK;
            level_reg    <= 2'h0;
            idle_cnt_reg <= {PW{1'b0}};
        end else begin
            case (state_reg)
                ST_TRACK: begin
                    // motion seen while tracking keeps the idle count at zero
                    if (motion_valid && motion_amount != 16'h0000)
                        idle_cnt_reg <= {PW{1'b0}};
                    else if (tick)
                        idle_cnt_reg <= idle_cnt_reg + 1'b1;
                    if (idle_cnt_reg >= IDLE_TICKS) begin
                        state_reg     <= ST_INACT;
                        level_reg     <= 2'h0;
                        dwell_cnt_reg <= dwell_time_reg[0];
                        sleep_cnt_reg <= sleep_time_reg[0];
                    end
                end
                ST_INACT: begin
                    // wake timer counts down the level's sleep time
                    if (tick) begin
                        if (sleep_cnt_reg <= 1) begin
                            state_reg     <= ST_CHECK;
                            check_cnt_reg <= 32'h0000_0000;
                            ev_wake       <= 1'b1;
                        end else begin
                            sleep_cnt_reg <= sleep_cnt_reg - 1'b1;
                        end
                        if (dwell_cnt_reg <= 1) begin
                            if (level_reg != last_level) begin
                                level_reg     <= level_reg + 1'b1;
                                dwell_cnt_reg <= dwell_time_reg[level_reg + 1'b1];
                                ev_step       <= 1'b1;
                            end
                        end else begin
                            dwell_cnt_reg <= dwell_cnt_reg - 1'b1;
                        end
                    end
                end
                ST_CHECK: begin
                    // laser on for a fixed check window; enough motion ends sleep
                    if (motion_big) begin
                        state_reg    <= ST_TRACK;
                        idle_cnt_reg <= {PW{1'b0}};
                        ev_motion    <= 1'b1;
                    end else if (check_cnt_reg == CHECK_CYC - 1) begin
                        state_reg     <= ST_INACT;
                        sleep_cnt_reg <= sleep_time_reg[level_reg];
                    end else begin
                        check_cnt_reg <= check_cnt_reg + 32'h0000_0001;
                    end
                end
                default: state_reg <= ST_TRACK;
            endcase
        end
    end

    // outputs from flip-flops; gates follow the state one cycle after it is entered
    always @(posedge clk_sys) begin
        if (reset) begin
            laser_on    <= 1'b1;
            detector_on <= 1'b1;
            tracking    <= 1'b1;
            irq         <= 1'b0;
        end else begin
            laser_on    <= (state_reg != ST_INACT);
            detector_on <= (state_reg != ST_INACT);
            tracking    <= (state_reg == ST_TRACK);
            irq         <= |(int_status_reg & int_mask_reg);
        end
    end

endmodule // motion_sleep_sequencer
`default_nettype wire

// File: dv/motion_sleep_chk.sv
// port assertions of the motion sleep sequencer
`timescale 1ns/1ps
`default_nettype none
module motion_sleep_chk #(
    parameter integer CHECK_CYC = 23
) (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        reset,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // motion and gates
    input wire logic        motion_valid,
    input wire logic        laser_on,
    input wire logic        detector_on,
    input wire logic        tracking,
    input wire logic        irq
);
    logic        en_reg;
    logic        mask_zero_reg;
    logic [15:0] check_cnt_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // shadow of enable and mask; mask starts nonzero so the quiet check waits for a write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            en_reg <= 1'b0;
            mask_zero_reg <= 1'b0;
        end else if (reg_wr && reg_addr == 8'h00) begin
            en_reg <= reg_wdata[0];
        end else if (reg_wr && reg_addr == 8'h03) begin
            mask_zero_reg <= (reg_wdata[2:0] == 3'h0);
        end
    end
    // length of the current lit run without tracking, a motion check
    always_ff @(posedge clk_sys) begin
        check_cnt_reg <= (laser_on && !tracking) ? check_cnt_reg + 16'h1 : 16'h0;
    end
    a_gates_together: assert property (laser_on == detector_on)
        else $error("laser and detector gates differ");
    a_read_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    a_dark_not_track: assert property (!laser_on |-> !tracking)
        else $error("tracking while inactive");
    a_off_stays_track: assert property ((!en_reg) [*4] |-> tracking && laser_on)
        else $error("left tracking while disabled");
    a_track_cause: assert property ($rose(tracking) |-> $past(motion_valid, 2) || !en_reg)
        else $error("tracking without motion");
    a_mask_quiet: assert property (mask_zero_reg && $past(mask_zero_reg) |-> !irq)
        else $error("irq with all masked");
    a_check_hold: assert property ($rose(laser_on) && !tracking |-> laser_on [*8])
        else $error("motion check cut short");
    a_check_len: assert property ($fell(laser_on) && !$past(tracking) |->
        check_cnt_reg == CHECK_CYC) else $error("motion check length wrong");
    c_wake: cover property ($rose(tracking));
    c_sleep: cover property ($fell(laser_on));
    c_irq: cover property ($rose(irq));
endmodule // motion_sleep_chk
bind motion_sleep_sequencer motion_sleep_chk #(.CHECK_CYC(CHECK_CYC)) chk_i (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motion_valid(motion_valid),
    .laser_on(laser_on), .detector_on(detector_on), .tracking(tracking), .irq(irq));
`default_nettype wire

// File: dv/motion_sleep_sequencer_bench.sv
// self-checking bench of the motion sleep sequencer
`timescale 1ns/1ps
`default_nettype none
`include "motion_sleep_map.vh"
module motion_sleep_sequencer_bench;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        motion_valid = 1'b0;
    logic [15:0] motion_amount = 16'h0;
    wire logic [31:0] reg_rdata;
    wire logic   laser_on, detector_on, tracking, irq;
    int          mismatches = 0;
    int          num_checks = 0;
    logic [31:0] v;
    always #50 clk_sys = ~clk_sys;
    // short ticks keep the run small: 10 cycles per ms, 23 per check, 2 ms idle
    motion_sleep_sequencer #(.TICK_CYC(10), .CHECK_CYC(23), .IDLE_TICKS(2)) uut (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .motion_valid(motion_valid), .motion_amount(motion_amount), .laser_on(laser_on),
        .detector_on(detector_on), .tracking(tracking), .irq(irq));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // a gap edge first, so strobes are never assigned twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // bounded wait on tracking or laser gate
    task automatic wait_for(input logic trk, input logic lv);
        int n;
        for (n = 0; n < 20000 && (trk ? tracking : laser_on) !== lv; n++) begin
            @(posedge clk_sys);
            #1;
        end
        if ((trk ? tracking : laser_on) !== lv) begin
            mismatches++;
            $display("mismatch wait expected %h seen %h", lv, ~lv);
            stop_test();
        end
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        #1 chk("tracking", 32'h1, {31'h0, tracking});
        rd(`MS_CTRL_OFS, v); chk("ctrl", `MS_CTRL_RESET, v);
        for (int i = 0; i < 4; i++) begin
            rd(`MS_LEVEL_BASE_OFS + 8'(4 * i), v); chk("sleep", `MS_SLEEP_RESET, v);
            rd(`MS_LEVEL_BASE_OFS + 8'(4 * i + 1), v); chk("thr", `MS_THRESH_RESET, v);
            rd(`MS_LEVEL_BASE_OFS + 8'(4 * i + 2), v); chk("dwell", `MS_DWELL_RESET, v);
            wr(`MS_LEVEL_BASE_OFS + 8'(4 * i), 32'(i + 1));
            wr(`MS_LEVEL_BASE_OFS + 8'(4 * i + 1), 32'(i + 5));
            wr(`MS_LEVEL_BASE_OFS + 8'(4 * i + 2), (i == 0) ? 32'h3 : 32'h1);
        end
        for (int i = 0; i < 4; i++) begin
            rd(`MS_LEVEL_BASE_OFS + 8'(4 * i + 1), v); chk("thr set", 32'(i + 5), v);
        end
        rd(8'h3f, v); chk("unmapped", 32'h0, v);
        repeat (100) @(posedge clk_sys);
        chk("disabled", 32'h1, {31'h0, tracking});
        wr(`MS_INT_MASK_OFS, 32'h7);
        wr(`MS_CTRL_OFS, 32'h1);
        wait_for(1'b0, 1'b0);
        chk("detector", 32'h0, {31'h0, detector_on});
        rd(`MS_STATUS_OFS, v); chk("status", 32'h04, v);
        @(posedge clk_sys);
        motion_valid <= 1'b1;
        motion_amount <= 16'h0004; // below every threshold
        wait_for(1'b0, 1'b1);
        rd(`MS_STATUS_OFS, v); chk("status", 32'h08, v);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`MS_INT_STATUS_OFS, 32'h7);
        wait_for(1'b0, 1'b0);
        chk("small motion", 32'h0, {31'h0, tracking});
        for (int n = 0; n < 500 && v[6:5] !== 2'h3; n++) rd(`MS_STATUS_OFS, v);
        chk("deepest", 32'h3, {30'h0, v[6:5]});
        rd(`MS_INT_STATUS_OFS, v); chk("step", 32'h1, {31'h0, v[2]});
        repeat (300) @(posedge clk_sys);
        rd(`MS_STATUS_OFS, v); chk("stays", 32'h3, {30'h0, v[6:5]});
        wait_for(1'b0, 1'b0);
        wait_for(1'b0, 1'b1);
        @(posedge clk_sys);
        motion_amount <= 16'h0008; // equals the deepest threshold
        wait_for(1'b1, 1'b1);
        // the level field keeps the deepest level while tracking; it restarts on the next sleep
        rd(`MS_STATUS_OFS, v); chk("woken", 32'h61, v);
        rd(`MS_INT_STATUS_OFS, v); chk("motion irq", 32'h1, {31'h0, v[1]});
        wr(`MS_INT_STATUS_OFS, 32'h7);
        wr(`MS_INT_MASK_OFS, 32'h0);
        motion_valid <= 1'b0;
        wait_for(1'b0, 1'b0);
        rd(`MS_STATUS_OFS, v); chk("restart", 32'h04, v);
        wait_for(1'b0, 1'b1);
        repeat (3) @(posedge clk_sys);
        chk("masked", 32'h0, {31'h0, irq});
        wr(`MS_CTRL_OFS, 32'h0);
        repeat (300) @(posedge clk_sys);
        chk("off again", 32'h1, {31'h0, tracking});
        stop_test();
    end
endmodule // motion_sleep_sequencer_bench
`default_nettype wire
